/* eccp_pkg.sv */
// Package with register map, field layout and timing constants of the capture/compare/PWM block.
package eccp_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] UNIT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_VALUE = 8'h04;
  localparam logic [7:0] OFS_STEER = 8'h08;
  localparam logic [7:0] OFS_TIMER_SELECT = 8'h30;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int DUTY_LOW_LSB = 4;
  localparam int OUT_CFG_LSB = 6;
  localparam int UNIT1_TSEL_LSB = 0;
  localparam int UNIT2_TSEL_LSB = 3;
  localparam int UNIT3_TSEL_LSB = 6;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;
  localparam logic [3:0] PRESCALE_4 = 4'h3;
  localparam logic [3:0] PRESCALE_16 = 4'hF;
  localparam logic [3:0] DEAD_BAND_CYCLES = 4'h2;
endpackage : eccp_pkg

/* eccp_unit.sv */
// One capture/compare/PWM unit: pin capture, compare match and enhanced PWM outputs.
module eccp_unit
  import eccp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] mode_control,
  input wire logic mode_write,
  input wire logic [15:0] value_reg,
  input wire logic [3:0] steer,
  input wire logic [15:0] cap_timer,
  input wire logic [7:0] pwm_timer,
  input wire logic pwm_period_start,
  input wire logic pin_sync,
  output logic capture_event,
  output logic [15:0] capture_value_pair,
  output logic compare_event,
  output logic special_trigger,
  output logic [3:0] pin_out,
  output logic [3:0] pin_en
);
  logic [3:0] mode_select_field;
  logic [1:0] output_config_field;
  logic [1:0] duty_low_bits;
  logic pin_prev;
  logic [3:0] prescale;
  logic cmp_latch;
  logic pwm_run;
  logic pwm_raw;
  logic [3:0] dead_cnt;
  logic is_capture;
  logic is_pwm;
  logic edge_hit;
  logic match;
  logic [3:0] level;
  logic [3:0] active_low;
  logic [9:0] duty;

  assign mode_select_field = mode_control[MODE_LSB +: 4];
  assign duty_low_bits = mode_control[DUTY_LOW_LSB +: 2];
  assign output_config_field = mode_control[OUT_CFG_LSB +: 2];
  assign is_capture = mode_select_field[3:2] == 2'b01;
  assign is_pwm = mode_select_field[3:2] == 2'b11;
  assign duty = {value_reg[7:0], duty_low_bits};
  assign match = (mode_select_field[3] && !is_pwm) || mode_select_field == MODE_CMP_TOGGLE
    ? value_reg == cap_timer : 1'b0;

  always_comb begin
    edge_hit = 1'b0;
    case (mode_select_field)
      MODE_CAP_FALL: edge_hit = pin_prev && !pin_sync;
      MODE_CAP_RISE: edge_hit = !pin_prev && pin_sync;
      MODE_CAP_RISE4: edge_hit = !pin_prev && pin_sync && prescale == PRESCALE_4;
      MODE_CAP_RISE16: edge_hit = !pin_prev && pin_sync && prescale == PRESCALE_16;
      default: edge_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_prev <= 1'b0;
      prescale <= 4'h0;
    end else begin
      pin_prev <= pin_sync;
      if (!is_capture || mode_write) begin
        prescale <= 4'h0;
      end else if (!pin_prev && pin_sync) begin
        prescale <= edge_hit ? 4'h0 : prescale + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      capture_event <= 1'b0;
      capture_value_pair <= 16'h0000;
    end else begin
      capture_event <= edge_hit;
      if (edge_hit) begin
        capture_value_pair <= cap_timer;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      compare_event <= 1'b0;
      special_trigger <= 1'b0;
      cmp_latch <= 1'b0;
    end else begin
      compare_event <= match;
      special_trigger <= match && mode_select_field == MODE_CMP_TRIG;
      if (mode_select_field == MODE_OFF) begin
        cmp_latch <= 1'b0;
      end else if (mode_write && mode_select_field == MODE_CMP_SET) begin
        cmp_latch <= 1'b0;
      end else if (mode_write && mode_select_field == MODE_CMP_CLR) begin
        cmp_latch <= 1'b1;
      end else if (match) begin
        case (mode_select_field)
          MODE_CMP_TOGGLE: cmp_latch <= !cmp_latch;
          MODE_CMP_SET: cmp_latch <= 1'b1;
          MODE_CMP_CLR: cmp_latch <= 1'b0;
          default: cmp_latch <= cmp_latch;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_run <= 1'b0;
      pwm_raw <= 1'b0;
      dead_cnt <= 4'h0;
    end else begin
      if (!is_pwm) begin
        pwm_run <= 1'b0;
      end else if (pwm_period_start) begin
        pwm_run <= 1'b1;
      end
      pwm_raw <= pwm_run && ({pwm_timer, 2'b00} < duty);
      if (pwm_raw != (pwm_run && ({pwm_timer, 2'b00} < duty))) begin
        dead_cnt <= DEAD_BAND_CYCLES;
      end else if (dead_cnt != 4'h0) begin
        dead_cnt <= dead_cnt - 4'h1;
      end
    end
  end

  assign active_low = mode_select_field[1] ? {mode_select_field[0], 1'b1,
    mode_select_field[0], 1'b1} : {mode_select_field[0], 1'b0, mode_select_field[0], 1'b0};

  always_comb begin
    level = 4'h0;
    pin_en = 4'h0;
    pin_out = 4'h0;
    if (!is_pwm) begin
      pin_en[0] = mode_select_field != MODE_OFF && !is_capture;
      pin_out[0] = cmp_latch;
    end else begin
      case (output_config_field)
        CFG_SINGLE: begin
          level = {4{pwm_raw}};
          pin_en = steer;
        end
        CFG_FWD: begin
          level = {pwm_raw, 1'b0, 1'b0, pwm_run};
          pin_en = 4'hF;
        end
        CFG_HALF: begin
          level = {1'b0, 1'b0, pwm_run && !pwm_raw && dead_cnt == 4'h0,
            pwm_raw && dead_cnt == 4'h0};
          pin_en = 4'h3;
        end
        default: begin
          level = {1'b0, pwm_run, pwm_raw, 1'b0};
          pin_en = 4'hF;
        end
      endcase
      pin_out = (level ^ active_low) & pin_en;
    end
  end
endmodule : eccp_unit

/* eccp_top.sv */
// Three enhanced capture/compare/PWM units behind an APB register slave.
module eccp_top
  import eccp_pkg::*;
#(
  parameter int UNITS = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_one_count,
  input wire logic [15:0] timer_three_count,
  input wire logic [7:0] timer_two_count,
  input wire logic [7:0] timer_four_count,
  input wire logic [7:0] timer_six_count,
  input wire logic [7:0] timer_eight_count,
  input wire logic [3:0] pwm_period_start,
  input wire logic [2:0] unit_io_pin,
  output logic [2:0] unit_interrupt_flag,
  output logic irq,
  output logic [2:0] timer_one_reset,
  output logic [2:0] timer_three_reset,
  output logic [2:0] adc_start,
  output logic [11:0] pwm_pins,
  output logic [11:0] pwm_pins_oe_n
);
  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [7:0] unit_mode_control [UNITS];
  logic [15:0] value_reg [UNITS];
  logic [3:0] steer_reg [UNITS];
  logic [7:0] unit_timer_select;
  logic [2:0] irq_mask;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_clean;
  logic [2:0] cap_ev;
  logic [2:0] cmp_ev;
  logic [2:0] trig;
  logic [2:0] sel_one;
  logic [15:0] cap_val [UNITS];
  logic [3:0] u_out [UNITS];
  logic [3:0] u_en [UNITS];
  logic [2:0] mode_wr;
  logic wr_go;
  logic rd_go;
  logic status_rd;
  logic [2:0] read_clear;
  logic [1:0] tsel [UNITS];
  logic [1:0] unit_idx;
  logic [7:0] local_ofs;
  logic [31:0] next_prdata;
  logic next_err;

  assign wr_go = psel && penable && pwrite;
  assign rd_go = psel && penable && !pwrite;
  assign unit_idx = paddr[5:4];
  assign local_ofs = paddr & (UNIT_STRIDE - 8'h01);
  assign status_rd = rd_go && paddr == OFS_IRQ_STATUS;
  // Only the bits that the read returned are cleared, so an event landing at the setup edge is kept.
  assign read_clear = status_rd ? prdata[2:0] : 3'h0;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Three stages; the level moves on only when the last two agree, filtering a late edge.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_clean <= 3'h0;
    end else begin
      pin_s1 <= unit_io_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= (pin_s2 & pin_s3) | (pin_clean & (pin_s2 | pin_s3));
    end
  end

  // ---------------------------------------------------------------------------
  // Timer selection and units
  // ---------------------------------------------------------------------------
  assign tsel[0] = unit_timer_select[UNIT1_TSEL_LSB +: 2];
  assign tsel[1] = unit_timer_select[UNIT2_TSEL_LSB +: 2];
  assign tsel[2] = unit_timer_select[UNIT3_TSEL_LSB +: 2];

  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit
      logic [7:0] pwm_t;
      assign sel_one[g] = tsel[g] == 2'b00;
      always_comb begin
        case (tsel[g])
          2'b00: pwm_t = timer_two_count;
          2'b01: pwm_t = timer_four_count;
          2'b10: pwm_t = timer_six_count;
          default: pwm_t = timer_eight_count;
        endcase
      end
      eccp_unit u_unit (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .mode_control(unit_mode_control[g]),
        .mode_write(mode_wr[g]),
        .value_reg(value_reg[g]),
        .steer(steer_reg[g]),
        .cap_timer(sel_one[g] ? timer_one_count : timer_three_count),
        .pwm_timer(pwm_t),
        .pwm_period_start(pwm_period_start[tsel[g]]),
        .pin_sync(pin_clean[g]),
        .capture_event(cap_ev[g]),
        .capture_value_pair(cap_val[g]),
        .compare_event(cmp_ev[g]),
        .special_trigger(trig[g]),
        .pin_out(u_out[g]),
        .pin_en(u_en[g])
      );
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pwm_pins[4*g +: 4] <= 4'h0;
          pwm_pins_oe_n[4*g +: 4] <= 4'hF;
          timer_one_reset[g] <= 1'b0;
          timer_three_reset[g] <= 1'b0;
          adc_start[g] <= 1'b0;
        end else begin
          pwm_pins[4*g +: 4] <= u_out[g];
          pwm_pins_oe_n[4*g +: 4] <= ~u_en[g];
          timer_one_reset[g] <= trig[g] && sel_one[g];
          timer_three_reset[g] <= trig[g] && !sel_one[g];
          adc_start[g] <= trig[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_wr <= 3'h0;
      unit_timer_select <= RESET_BYTE;
      irq_mask <= 3'h0;
      for (int i = 0; i < UNITS; i++) begin
        unit_mode_control[i] <= RESET_BYTE;
        value_reg[i] <= 16'h0000;
        steer_reg[i] <= 4'h1;
      end
    end else begin
      mode_wr <= 3'h0;
      if (wr_go && paddr == OFS_TIMER_SELECT) begin
        unit_timer_select <= pwdata[7:0];
      end
      if (wr_go && paddr == OFS_IRQ_MASK) begin
        irq_mask <= pwdata[2:0];
      end
      for (int i = 0; i < UNITS; i++) begin
        if (wr_go && unit_idx == 2'(i) && local_ofs == OFS_MODE_CONTROL) begin
          unit_mode_control[i] <= pwdata[7:0];
          mode_wr[i] <= 1'b1;
        end
        if (wr_go && unit_idx == 2'(i) && local_ofs == OFS_VALUE) begin
          value_reg[i] <= pwdata[15:0];
        end
        if (wr_go && unit_idx == 2'(i) && local_ofs == OFS_STEER) begin
          steer_reg[i] <= pwdata[3:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt flags
  // ---------------------------------------------------------------------------
  // A read of the status register clears the bits that it returned; a same-cycle event still sets its bit.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unit_interrupt_flag <= 3'h0;
      irq <= 1'b0;
    end else begin
      unit_interrupt_flag <= (unit_interrupt_flag & ~read_clear) | cap_ev | cmp_ev;
      irq <= |(((unit_interrupt_flag & ~read_clear) | cap_ev | cmp_ev) & irq_mask);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == OFS_TIMER_SELECT) begin
      next_prdata[7:0] = unit_timer_select;
    end else if (paddr == OFS_IRQ_STATUS) begin
      next_prdata[2:0] = unit_interrupt_flag;
    end else if (paddr == OFS_IRQ_MASK) begin
      next_prdata[2:0] = irq_mask;
    end else if (unit_idx < 2'(UNITS) && local_ofs == OFS_MODE_CONTROL) begin
      next_prdata[7:0] = unit_mode_control[unit_idx];
    end else if (unit_idx < 2'(UNITS) && local_ofs == OFS_VALUE) begin
      next_prdata[15:0] = unit_mode_control[unit_idx][3:2] == 2'b01 ? cap_val[unit_idx]
        : value_reg[unit_idx];
    end else if (unit_idx < 2'(UNITS) && local_ofs == OFS_STEER) begin
      next_prdata[3:0] = steer_reg[unit_idx];
    end else begin
      next_err = 1'b1;
    end
  end

  // Zero wait states: ready follows the setup cycle, so every access takes two cycles.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end
endmodule : eccp_top

/* eccp_top_asserts.sv */
// Checker of the capture/compare/PWM block at the ports of its top module.
module eccp_top_checker
  import eccp_pkg::*;
#(
  parameter int UNITS = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] unit_interrupt_flag,
  input wire logic irq,
  input wire logic [2:0] timer_one_reset,
  input wire logic [2:0] timer_three_reset,
  input wire logic [2:0] adc_start,
  input wire logic [11:0] pwm_pins_oe_n
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ready_follows_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  flag_sticky_a: assert property (
    (|($past(unit_interrupt_flag) & ~unit_interrupt_flag)) |->
    $past(psel && penable && !pwrite && paddr == OFS_IRQ_STATUS))
    else $error("flag cleared without status read");
  irq_cause_a: assert property (irq |-> (|unit_interrupt_flag))
    else $error("irq without flag");
  trig_pulse_a: assert property (|timer_one_reset |=> timer_one_reset == 3'h0)
    else $error("timer reset longer than one cycle");
  adc_trig_a: assert property (adc_start == (timer_one_reset | timer_three_reset))
    else $error("conversion start apart from trigger");
  trig_flag_a: assert property (
    ((timer_one_reset | timer_three_reset) & ~unit_interrupt_flag) == 3'h0)
    else $error("trigger without flag");
  one_pair_a: assert property ((timer_one_reset & timer_three_reset) == 3'h0)
    else $error("both timer pairs reset");
  release_pins_a: assert property ($rose(rst_n) |-> pwm_pins_oe_n == 12'hFFF)
    else $error("pins driven after reset");
endmodule : eccp_top_checker

bind eccp_top eccp_top_checker #(.UNITS(UNITS)) i_checker (.ref_clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .unit_interrupt_flag, .irq,
  .timer_one_reset, .timer_three_reset, .adc_start, .pwm_pins_oe_n);

/* pin_stage_model.sv */
// Model of the pins around the block: capture sources and pulled-down output pads.
module pin_stage_model (
  input wire logic [2:0] drive_level,
  input wire logic [11:0] pwm_pins,
  input wire logic [11:0] pwm_pins_oe_n,
  output logic [2:0] unit_io_pin,
  output logic [11:0] pads
);
  // -----
  // Pins
  // -----
  // The bench moves the source just after clock edges, so it passes straight through.
  assign unit_io_pin = drive_level;
  // Released pads fall to the pull-down, so a stale driven level never lingers.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pads[i] = pwm_pins_oe_n[i] ? 1'b0 : pwm_pins[i];
    end
  end
endmodule : pin_stage_model

/* eccp_top_bench.sv */
// Self-checking bench of the capture/compare/PWM block with its pin stage model.
module eccp_top_bench
  import eccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // -------
  // Signals
  // -------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, timer_two_count = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [15:0] timer_one_count = 16'h0, timer_three_count = 16'h0;
  logic [3:0] pwm_period_start = 4'h0;
  logic [2:0] drive_level = 3'h0, unit_io_pin, unit_interrupt_flag;
  logic [2:0] timer_one_reset, timer_three_reset, adc_start;
  logic [11:0] pwm_pins, pwm_pins_oe_n, pads;
  logic pready, pslverr, irq, err_q;
  int fails = 0, checks = 0, trig_seen = 0, adc_seen = 0;
  eccp_top i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_one_count, .timer_three_count, .timer_two_count,
    .timer_four_count(8'h00), .timer_six_count(8'h00), .timer_eight_count(8'h00),
    .pwm_period_start, .unit_io_pin, .unit_interrupt_flag, .irq, .timer_one_reset,
    .timer_three_reset, .adc_start, .pwm_pins, .pwm_pins_oe_n);
  pin_stage_model i_pins (.drive_level, .pwm_pins, .pwm_pins_oe_n, .unit_io_pin, .pads);
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (timer_one_reset[0] === 1'b1) trig_seen++;
    if (adc_start[0] === 1'b1) adc_seen++;
  end
  // -----
  // Tasks
  // -----
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) fails++;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  function automatic logic [7:0] ua(input int u, input logic [7:0] o);
    return 8'(u) * UNIT_STRIDE + o;
  endfunction : ua
  task automatic pin(input int u, input logic lvl);
    drive_level[u] <= lvl;
    repeat (12) @(posedge ref_clk);
  endtask : pin
  task automatic match();
    timer_one_count <= 16'h0500;
    @(posedge ref_clk);
    timer_one_count <= 16'h0501;
    repeat (4) @(posedge ref_clk);
  endtask : match
  task automatic check_reset();
    logic [7:0] adr [6] = '{8'h00, 8'h10, 8'h20, OFS_TIMER_SELECT, OFS_STEER, 8'h3C};
    chk("oe_n", 32'hFFF, 32'(pwm_pins_oe_n));
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, adr[i], 32'h0);
      chk("reset read", (i == 4) ? 32'h1 : 32'h0, rd_q);
      chk("slverr", (i == 5) ? 32'h1 : 32'h0, 32'(err_q));
    end
  endtask : check_reset
  task automatic capture_select();
    timer_one_count <= 16'h1111;
    timer_three_count <= 16'h3333;
    xfer(1'b1, OFS_TIMER_SELECT, 32'h88);
    for (int u = 0; u < 3; u++) begin
      xfer(1'b1, ua(u, OFS_MODE_CONTROL), 32'(MODE_CAP_RISE));
    end
    xfer(1'b0, OFS_IRQ_STATUS, 32'h0);
    for (int u = 0; u < 3; u++) begin
      pin(u, 1'b1);
      pin(u, 1'b0);
    end
    chk("pads", 32'h0, 32'(pads[3:1]));
    timer_one_count <= 16'hBEEF;
    pin(0, 1'b1);
    pin(0, 1'b0);
    for (int u = 0; u < 3; u++) begin
      xfer(1'b0, ua(u, OFS_VALUE), 32'h0);
      chk("capture", (u == 0) ? 32'hBEEF : 32'h3333, rd_q);
    end
    chk("flags", 32'h7, 32'(unit_interrupt_flag));
    chk("irq masked", 32'h0, 32'(irq));
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    @(posedge ref_clk);
    chk("irq", 32'h1, 32'(irq));
    xfer(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("status", 32'h7, rd_q & 32'h7);
    repeat (2) @(posedge ref_clk);
    chk("cleared", 32'h0, {28'h0, unit_interrupt_flag, 1'b0} | 32'(irq));
  endtask : capture_select
  task automatic prescale();
    logic [3:0] md [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
    int cnt [4] = '{1, 1, 4, 16};
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, 8'h00, 32'(md[m]));
      pin(0, 1'b1);
      pin(0, 1'b0);
      pin(0, 1'b1);
      pin(0, 1'b0);
      xfer(1'b1, 8'h00, 32'(MODE_OFF));
      xfer(1'b1, 8'h00, 32'(md[m]));
      xfer(1'b0, OFS_IRQ_STATUS, 32'h0);
      for (int k = 1; k <= cnt[m]; k++) begin
        pin(0, 1'b1);
        if (m == 0) chk("rise", 32'h0, 32'(unit_interrupt_flag[0]));
        pin(0, 1'b0);
        chk("event", 32'(k == cnt[m]), 32'(unit_interrupt_flag[0]));
      end
    end
  endtask : prescale
  task automatic compare();
    logic a0;
    xfer(1'b1, 8'h00, 32'(MODE_CMP_SET));
    xfer(1'b1, OFS_VALUE, 32'h0500);
    xfer(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("pin low", 32'h0, 32'(pwm_pins[0]));
    match();
    chk("pin set", 32'h3, {30'h0, pwm_pins[0], unit_interrupt_flag[0]});
    xfer(1'b1, 8'h00, 32'(MODE_CMP_SOFT));
    xfer(1'b0, OFS_IRQ_STATUS, 32'h0);
    a0 = pwm_pins[0];
    match();
    chk("pin kept", {30'h0, a0, 1'b1}, {30'h0, pwm_pins[0], unit_interrupt_flag[0]});
    xfer(1'b1, 8'h00, 32'(MODE_CMP_TOGGLE));
    match();
    chk("pin toggled", 32'h0, 32'(pwm_pins[0]));
    xfer(1'b1, 8'h00, 32'(MODE_CMP_CLR));
    repeat (2) @(posedge ref_clk);
    chk("pin init", 32'h1, 32'(pwm_pins[0]));
    match();
    chk("pin cleared", 32'h0, 32'(pwm_pins[0]));
    xfer(1'b1, 8'h00, 32'(MODE_CMP_TRIG));
    trig_seen = 0;
    adc_seen = 0;
    match();
    chk("trigger", 32'h11, 32'(trig_seen * 16 + adc_seen));
  endtask : compare
  task automatic pwm();
    logic [1:0] cfg [4] = '{CFG_FWD, CFG_REV, CFG_HALF, CFG_SINGLE};
    logic [3:0] hi [4] = '{4'h9, 4'h6, 4'h1, 4'h4};
    logic [3:0] lo [4] = '{4'h1, 4'h4, 4'h2, 4'h0};
    logic [3:0] drv [4] = '{4'hF, 4'hF, 4'h3, 4'h4};
    logic [3:0] pol [4] = '{4'h0, 4'hA, 4'h5, 4'hF};
    xfer(1'b1, OFS_STEER, 32'h4);
    xfer(1'b1, OFS_VALUE, 32'h40);
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 4; p++) begin
        xfer(1'b1, 8'h00, 32'(MODE_OFF));
        timer_two_count <= 8'h40;
        xfer(1'b1, 8'h00, {24'h0, cfg[c], 2'b11, 4'hC | 4'(p)});
        repeat (4) @(posedge ref_clk);
        chk("held", 32'h0, {28'h0, (pwm_pins[3:0] ^ pol[p]) & ~pwm_pins_oe_n[3:0]});
        pwm_period_start[0] <= 1'b1;
        @(posedge ref_clk);
        pwm_period_start[0] <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("drive", {28'h0, drv[c]}, {28'h0, ~pwm_pins_oe_n[3:0]});
        chk("on", {28'h0, (hi[c] ^ pol[p]) & drv[c]}, {28'h0, pwm_pins[3:0] & drv[c]});
        timer_two_count <= 8'h41;
        repeat (6) @(posedge ref_clk);
        chk("off", {28'h0, (lo[c] ^ pol[p]) & drv[c]}, {28'h0, pwm_pins[3:0] & drv[c]});
      end
    end
  endtask : pwm
  // --------
  // Sequence
  // --------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check_reset();
    capture_select();
    prescale();
    compare();
    pwm();
    conclude();
  end
  // The whole run needs under two thousand cycles, so this only trips on a hang.
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    conclude();
  end
endmodule : eccp_top_bench
